// >>> hw/shs_pkg.sv
package shs_pkg;

   // ---------------------------------------------------------------
   // Clock and polling rates
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned RATE_104_DHZ  = 1040;
   localparam int unsigned RATE_52_DHZ   = 520;
   localparam int unsigned RATE_26_DHZ   = 260;
   localparam int unsigned RATE_12_5_DHZ = 125;
   localparam int unsigned PERIOD_104_CYC  = (CLK_HZ * 10) / RATE_104_DHZ;
   localparam int unsigned PERIOD_52_CYC   = (CLK_HZ * 10) / RATE_52_DHZ;
   localparam int unsigned PERIOD_26_CYC   = (CLK_HZ * 10) / RATE_26_DHZ;
   localparam int unsigned PERIOD_12_5_CYC = (CLK_HZ * 10) / RATE_12_5_DHZ;
   localparam int unsigned TIMER_W         = 22;

   // Rate levels: 0 off, 1 = 12.5 Hz, 2 = 26 Hz, 3 = 52 Hz, 4 = 104 Hz or faster
   localparam logic [2:0] LEVEL_OFF = 3'h0;
   localparam logic [2:0] LEVEL_MAX = 3'h4;

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [9:0] IDX_FIRST        = 10'h014;
   localparam logic [9:0] IDX_HUB_CONFIG   = 10'h014;
   localparam logic [9:0] IDX_EXT0_ADDR    = 10'h015;
   localparam logic [9:0] IDX_EXT0_REG     = 10'h016;
   localparam logic [9:0] IDX_EXT0_CONFIG  = 10'h017;
   localparam logic [9:0] IDX_EXT1_ADDR    = 10'h018;
   localparam logic [9:0] IDX_EXT1_REG     = 10'h019;
   localparam logic [9:0] IDX_EXT1_CONFIG  = 10'h01a;
   localparam logic [9:0] IDX_EXT2_ADDR    = 10'h01b;
   localparam logic [9:0] IDX_EXT2_REG     = 10'h01c;
   localparam logic [9:0] IDX_EXT2_CONFIG  = 10'h01d;
   localparam logic [9:0] IDX_EXT3_ADDR    = 10'h01e;
   localparam logic [9:0] IDX_EXT3_REG     = 10'h01f;
   localparam logic [9:0] IDX_EXT3_CONFIG  = 10'h020;
   localparam logic [9:0] IDX_LAST         = 10'h020;
   localparam logic [9:0] IDX_HUB_STATUS   = 10'h024;
   localparam int unsigned NUM_REGS        = 13;

   // Offsets inside the register array, per sensor stride of three
   localparam logic [3:0] OFS_ADDR   = 4'h1;
   localparam logic [3:0] OFS_REG    = 4'h2;
   localparam logic [3:0] OFS_CONFIG = 4'h3;
   localparam logic [3:0] SENSOR_STRIDE = 4'h3;

   // Field positions
   localparam int unsigned POS_SENSOR_COUNT = 0;
   localparam int unsigned POS_TARGET_ADDR  = 1;
   localparam int unsigned POS_READ_BIT     = 0;
   localparam int unsigned POS_READ_COUNT   = 0;
   localparam int unsigned POS_QUEUE_EN     = 3;
   localparam int unsigned POS_POLL_RATE    = 6;

   localparam logic [7:0]  REG_RESET = 8'h00;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SELECT = 2'b01,
      ST_WAIT   = 2'b10,
      ST_NEXT   = 2'b11
   } shs_state_t;

   typedef struct packed {
      logic [1:0] sensor;
      logic [6:0] targetAddr;
      logic [7:0] targetReg;
      logic       write;
      logic [7:0] writeData;
      logic [2:0] readCount;
      logic       queueEnable;
   } shs_txn_t;

   typedef struct packed {
      logic [11:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } shs_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } shs_apb_rsp_t;

endpackage

// >>> hw/shs_slave_table.sv
//
// Overview of operation
// - Poll-rate code picks 104/52/26/12.5 Hz, reset 00
// - Faster of accel and gyro output rates overrides hub rate if slower
// - Sensor one uses 8-bit target register
// - Sensor one read count, reset 000
// - Sensor one queue enable, reset low
// - Sensor two 7-bit target address
// - Sensor two read only when enabled
// - Sensor two target register address
// - Sensor two read count, reset 000
// - Sensor two queue enable, reset low
// - Sensor three address and read enable
// - Sensor three target register address
// - Sensor three read count, reset 000
// - Sensor three queue enable, reset low
// - Sensor four address and read enable
// - Sensor four target register, read enabled only
// - Sensor one direction: 0 write, 1 read
// - Sensor count field: one to four sensors
// - Sensor one 7-bit target address
// - Sensor four read count, reset 000
//
module shs_slave_table #(
   parameter int unsigned PERIOD_104  = shs_pkg::PERIOD_104_CYC,
   parameter int unsigned PERIOD_52   = shs_pkg::PERIOD_52_CYC,
   parameter int unsigned PERIOD_26   = shs_pkg::PERIOD_26_CYC,
   parameter int unsigned PERIOD_12_5 = shs_pkg::PERIOD_12_5_CYC
) (
   // Clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   rst_n,
   // APB slave
   input  wire shs_pkg::shs_apb_req_t  apbReq,
   output shs_pkg::shs_apb_rsp_t       apbRsp,
   // Sensor output rate levels
   input  wire logic [2:0]             accelRateLevel,
   input  wire logic [2:0]             gyroRateLevel,
   // Write data byte for sensor one
   input  wire logic [7:0]             extWriteData,
   // Transaction request to I2C engine
   output logic                        txnValid,
   output shs_pkg::shs_txn_t           txn,
   input  wire logic                   txnDone,
   // Status
   output logic                        hubBusy,
   output logic                        pollTick
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [shs_pkg::NUM_REGS-1:0][7:0] regs;
      shs_pkg::shs_apb_rsp_t             rsp;
      shs_pkg::shs_state_t               fsm;
      logic [1:0]                        sensor;
      logic [shs_pkg::TIMER_W-1:0]       timer;
      logic                              tick;
      logic                              txnValid;
      shs_pkg::shs_txn_t                 txn;
      logic                              busy;
   } shs_state_reg_t;

   shs_state_reg_t s_q;
   shs_state_reg_t s_d;

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   function automatic logic [3:0] sensorBase(input logic [1:0] idx);
      sensorBase = 4'(idx * shs_pkg::SENSOR_STRIDE);
   endfunction

   function automatic logic [2:0] clampLevel(input logic [2:0] lvl);
      clampLevel = (lvl > shs_pkg::LEVEL_MAX) ? shs_pkg::LEVEL_MAX : lvl;
   endfunction

   function automatic logic [shs_pkg::TIMER_W-1:0] periodOf(input logic [2:0] lvl);
      if (lvl == 3'h4) begin
         periodOf = shs_pkg::TIMER_W'(PERIOD_104);
      end else if (lvl == 3'h3) begin
         periodOf = shs_pkg::TIMER_W'(PERIOD_52);
      end else if (lvl == 3'h2) begin
         periodOf = shs_pkg::TIMER_W'(PERIOD_26);
      end else begin
         periodOf = shs_pkg::TIMER_W'(PERIOD_12_5);
      end
   endfunction

   // ---------------------------------------------------------------
   // Field extraction
   // ---------------------------------------------------------------
   function automatic logic readBitOf(input logic [7:0] addrByte);
      readBitOf = addrByte[shs_pkg::POS_READ_BIT];
   endfunction

   function automatic logic [6:0] targetAddrOf(input logic [7:0] addrByte);
      targetAddrOf = addrByte[shs_pkg::POS_TARGET_ADDR +: 7];
   endfunction

   function automatic logic [2:0] readCountOf(input logic [7:0] cfgByte);
      readCountOf = cfgByte[shs_pkg::POS_READ_COUNT +: 3];
   endfunction

   function automatic logic queueOf(input logic [7:0] cfgByte);
      queueOf = cfgByte[shs_pkg::POS_QUEUE_EN];
   endfunction

   function automatic logic [2:0] maxLevel(input logic [2:0] a, input logic [2:0] b);
      maxLevel = (a > b) ? a : b;
   endfunction

   function automatic logic [2:0] minLevel(input logic [2:0] a, input logic [2:0] b);
      minLevel = (a < b) ? a : b;
   endfunction

   function automatic logic isMapped(input logic [9:0] idx);
      isMapped = (idx >= shs_pkg::IDX_FIRST && idx <= shs_pkg::IDX_LAST) ||
                 (idx == shs_pkg::IDX_HUB_STATUS);
   endfunction

   function automatic logic [31:0] statusWord(input shs_state_reg_t s, input logic [2:0] lvl);
      statusWord = {24'h00_0000, s.busy, s.sensor, lvl, s.fsm};
   endfunction

   function automatic shs_pkg::shs_txn_t buildTxn(input logic [1:0] idx,
                                                  input logic [7:0] addrByte,
                                                  input logic [7:0] regByte,
                                                  input logic [7:0] cfgByte,
                                                  input logic [7:0] wrData,
                                                  input logic       isWrite);
      buildTxn             = '0;
      buildTxn.sensor      = idx;
      buildTxn.targetAddr  = targetAddrOf(addrByte);
      buildTxn.targetReg   = regByte;
      buildTxn.write       = isWrite;
      buildTxn.writeData   = wrData;
      buildTxn.readCount   = isWrite ? 3'h0 :
                             readCountOf(cfgByte);
      buildTxn.queueEnable = !isWrite && queueOf(cfgByte);
   endfunction

   // ---------------------------------------------------------------
   // Rate selection
   // ---------------------------------------------------------------
   logic [1:0] pollRate;
   logic [2:0] hubLevel;
   logic [2:0] sensorLevel;
   logic [2:0] effLevel;

   always_comb begin
      pollRate    = s_q.regs[shs_pkg::OFS_CONFIG][shs_pkg::POS_POLL_RATE +: 2];
      hubLevel    = 3'(shs_pkg::LEVEL_MAX - {1'b0, pollRate});
      sensorLevel = maxLevel(clampLevel(accelRateLevel), clampLevel(gyroRateLevel));
      effLevel    = minLevel(sensorLevel, hubLevel);
   end

   // ---------------------------------------------------------------
   // Per-sensor view of the table
   // ---------------------------------------------------------------
   wire logic [7:0] tabAddr [4];
   wire logic [7:0] tabReg  [4];
   wire logic [7:0] tabCfg  [4];
   wire logic       readOn  [4];

   for (genvar g = 0; g < 4; g++) begin : gSensor
      assign tabAddr[g] = s_q.regs[sensorBase(2'(g)) + shs_pkg::OFS_ADDR];
      assign tabReg[g]  = s_q.regs[sensorBase(2'(g)) + shs_pkg::OFS_REG];
      assign tabCfg[g]  = s_q.regs[sensorBase(2'(g)) + shs_pkg::OFS_CONFIG];
      // Reads need the read bit and a nonzero count
      assign readOn[g]  = readBitOf(tabAddr[g]) &&
                          (readCountOf(tabCfg[g]) != 3'h0);
   end

   // ---------------------------------------------------------------
   // Current sensor
   // ---------------------------------------------------------------
   logic [1:0] sensorCount;
   logic [7:0] curAddrByte;
   logic [7:0] curRegByte;
   logic [7:0] curCfgByte;
   logic       curWrite;
   logic       curEnable;

   always_comb begin
      sensorCount = s_q.regs[0][shs_pkg::POS_SENSOR_COUNT +: 2];
      curAddrByte = tabAddr[s_q.sensor];
      curRegByte  = tabReg[s_q.sensor];
      curCfgByte  = tabCfg[s_q.sensor];
      // Sensor one writes when its direction bit is low
      curWrite    = (s_q.sensor == 2'h0) && !readBitOf(curAddrByte);
      curEnable   = curWrite || readOn[s_q.sensor];
   end

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   logic [9:0] apbIdx;
   logic [3:0] arrIdx;
   logic       apbMapped;
   logic       apbAccess;
   logic       apbFirst;
   logic       apbCommit;

   always_comb begin
      apbIdx    = apbReq.paddr[11:2];
      arrIdx    = 4'(apbIdx - shs_pkg::IDX_FIRST);
      apbMapped = isMapped(apbIdx);
      apbAccess = apbReq.psel && apbReq.penable;
      // First access edge answers, the ready edge commits
      apbFirst  = apbAccess && !s_q.rsp.pready;
      apbCommit = apbAccess && s_q.rsp.pready && apbReq.pwrite && apbMapped &&
                  (apbIdx != shs_pkg::IDX_HUB_STATUS);
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;

      // APB: one wait state, write and read data at the ready edge
      s_d.rsp.pready  = apbFirst;
      s_d.rsp.pslverr = apbFirst && !apbMapped;
      if (apbFirst) begin
         if (!apbMapped || apbReq.pwrite) begin
            s_d.rsp.prdata = 32'h0000_0000;
         end else if (apbIdx == shs_pkg::IDX_HUB_STATUS) begin
            s_d.rsp.prdata = statusWord(s_q, effLevel);
         end else begin
            s_d.rsp.prdata = {24'h00_0000, s_q.regs[arrIdx]};
         end
      end
      if (apbCommit) begin
         s_d.regs[arrIdx] = apbReq.pwdata[7:0];
      end

      // Poll timer paced by the effective rate
      s_d.tick = 1'b0;
      if (effLevel == shs_pkg::LEVEL_OFF) begin
         s_d.timer = periodOf(effLevel);
      end else if (s_q.timer == '0) begin
         s_d.timer = periodOf(effLevel) - 1'b1;
         s_d.tick  = 1'b1;
      end else if (s_q.timer >= periodOf(effLevel)) begin
         s_d.timer = periodOf(effLevel) - 1'b1;
      end else begin
         s_d.timer = s_q.timer - 1'b1;
      end

      // Hub cycle sequencer
      case (s_q.fsm)
         shs_pkg::ST_IDLE: begin
            s_d.busy = 1'b0;
            if (s_q.tick) begin
               s_d.sensor = 2'h0;
               s_d.busy   = 1'b1;
               s_d.fsm    = shs_pkg::ST_SELECT;
            end
         end
         shs_pkg::ST_SELECT: begin
            if (curEnable) begin
               s_d.txn      = buildTxn(s_q.sensor, curAddrByte, curRegByte, curCfgByte,
                                       extWriteData, curWrite);
               s_d.txnValid = 1'b1;
               s_d.fsm      = shs_pkg::ST_WAIT;
            end else begin
               s_d.fsm = shs_pkg::ST_NEXT;
            end
         end
         shs_pkg::ST_WAIT: begin
            if (txnDone) begin
               s_d.txnValid = 1'b0;
               s_d.fsm      = shs_pkg::ST_NEXT;
            end
         end
         shs_pkg::ST_NEXT: begin
            if (s_q.sensor == sensorCount) begin
               s_d.fsm = shs_pkg::ST_IDLE;
            end else begin
               s_d.sensor = s_q.sensor + 2'h1;
               s_d.fsm    = shs_pkg::ST_SELECT;
            end
         end
         default: begin
            s_d.fsm = shs_pkg::ST_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_q          <= '0;
         s_q.regs     <= {shs_pkg::NUM_REGS{shs_pkg::REG_RESET}};
         s_q.rsp      <= '0;
         s_q.fsm      <= shs_pkg::ST_IDLE;
         s_q.sensor   <= 2'h0;
         s_q.timer    <= shs_pkg::TIMER_W'(PERIOD_12_5);
         s_q.tick     <= 1'b0;
         s_q.txnValid <= 1'b0;
         s_q.txn      <= '0;
         s_q.busy     <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign apbRsp   = s_q.rsp;
   assign txnValid = s_q.txnValid;
   assign txn      = s_q.txn;
   assign hubBusy  = s_q.busy;
   assign pollTick = s_q.tick;

endmodule

// >>> sim/shs_sensor_model.sv
module shs_sensor_model (
   // Hub request
   input wire logic sys_clk,
   input wire logic txnValid,
   input wire logic slowMode,
   // Completion
   output logic     txnDone
);
   timeunit 1ns;
   timeprecision 1ps;
   int   waitCnt = 0;
   logic doneQ = 1'b0;
   initial txnDone = 1'b0;
   // One completion pulse per request, after a short or long bus time
   always @(posedge sys_clk) begin
      txnDone <= 1'b0;
      if (txnValid !== 1'b1) begin
         doneQ <= 1'b0;
         waitCnt <= 0;
      end else if (!doneQ && waitCnt >= (slowMode ? 6 : 1)) begin
         txnDone <= 1'b1;
         doneQ <= 1'b1;
      end else waitCnt <= waitCnt + 1;
   end
endmodule

// >>> sim/shs_slave_table_properties.sv
module shs_slave_table_properties #(
   parameter int unsigned PERIOD_104  = shs_pkg::PERIOD_104_CYC,
   parameter int unsigned PERIOD_52   = shs_pkg::PERIOD_52_CYC,
   parameter int unsigned PERIOD_26   = shs_pkg::PERIOD_26_CYC,
   parameter int unsigned PERIOD_12_5 = shs_pkg::PERIOD_12_5_CYC
) (
   // Clock and reset
   input wire logic                  sys_clk,
   input wire logic                  rst_n,
   // Register bus
   input wire shs_pkg::shs_apb_req_t apbReq,
   input wire shs_pkg::shs_apb_rsp_t apbRsp,
   // Hub side
   input wire logic [2:0]            accelRateLevel,
   input wire logic [2:0]            gyroRateLevel,
   input wire logic [7:0]            extWriteData,
   input wire logic                  txnValid,
   input wire shs_pkg::shs_txn_t     txn,
   input wire logic                  txnDone,
   input wire logic                  hubBusy,
   input wire logic                  pollTick
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic [9:0] idx;
   logic       mapped;
   assign idx = apbReq.paddr[11:2];
   assign mapped = (idx >= shs_pkg::IDX_FIRST && idx <= shs_pkg::IDX_LAST)
      || idx == shs_pkg::IDX_HUB_STATUS;
   sequence access_s;
      apbReq.psel && apbReq.penable && !apbRsp.pready;
   endsequence
   sequence answer_s;
      apbRsp.pready ##1 !apbRsp.pready;
   endsequence
   apb_one_wait_a: assert property (access_s |=> answer_s) else $error("apb answer late");
   apb_err_map_a: assert property (apbRsp.pready |-> apbRsp.pslverr == !mapped)
      else $error("apb error flag wrong");
   apb_upper_zero_a: assert property (apbRsp.pready |-> apbRsp.prdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   txn_hold_a: assert property (txnValid && $past(txnValid) |-> $stable(txn))
      else $error("request changed");
   txn_release_a: assert property (txnValid && txnDone |=> !txnValid [*2])
      else $error("request not released");
   write_fields_a: assert property (txnValid && txn.write |-> txn.sensor == 2'h0
      && txn.readCount == 3'h0 && !txn.queueEnable) else $error("bad write request");
   read_count_a: assert property (txnValid && !txn.write |-> txn.readCount != 3'h0)
      else $error("read with zero count");
   busy_txn_a: assert property (txnValid |-> hubBusy) else $error("request outside cycle");
   tick_start_a: assert property (pollTick && !hubBusy |=> hubBusy)
      else $error("tick did not start cycle");
   tick_pulse_a: assert property (pollTick |=> !pollTick) else $error("tick too long");
endmodule

bind shs_slave_table shs_slave_table_properties #(
   .PERIOD_104(PERIOD_104), .PERIOD_52(PERIOD_52), .PERIOD_26(PERIOD_26),
   .PERIOD_12_5(PERIOD_12_5)
) u_props (.sys_clk(sys_clk), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
   .accelRateLevel(accelRateLevel), .gyroRateLevel(gyroRateLevel),
   .extWriteData(extWriteData), .txnValid(txnValid), .txn(txn), .txnDone(txnDone),
   .hubBusy(hubBusy), .pollTick(pollTick));

// >>> sim/shs_slave_table_tb.sv
module shs_slave_table_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [9:0] idx; logic [7:0] wd, ex; logic er;} shs_row_t;
   localparam int P = 40;
   logic                  sys_clk = 1'b0;
   logic                  rst_n = 1'b0;
   shs_pkg::shs_apb_req_t apbReq = '0;
   shs_pkg::shs_apb_rsp_t apbRsp;
   logic [2:0]            accelRateLevel = 3'h4;
   logic [2:0]            gyroRateLevel = 3'h4;
   logic [7:0]            extWriteData = 8'h00;
   logic                  txnValid, txnDone, hubBusy, pollTick;
   logic                  slowMode = 1'b0;
   shs_pkg::shs_txn_t     txn;
   shs_pkg::shs_txn_t     got [4];
   logic [31:0]           rd;
   logic                  err;
   int                    fails = 0;
   int                    checks_done = 0;
   // Unused bits always written as zero
   shs_row_t rows [15] = '{'{10'h014, 8'h03, 8'h03, 0}, '{10'h015, 8'hab, 8'hab, 0},
      '{10'h016, 8'ha5, 8'ha5, 0}, '{10'h017, 8'hcf, 8'hcf, 0}, '{10'h018, 8'hff, 8'hff, 0},
      '{10'h019, 8'h81, 8'h81, 0}, '{10'h01a, 8'h0f, 8'h0f, 0}, '{10'h01b, 8'h7e, 8'h7e, 0},
      '{10'h01c, 8'h42, 8'h42, 0}, '{10'h01d, 8'h09, 8'h09, 0}, '{10'h01e, 8'he3, 8'he3, 0},
      '{10'h01f, 8'h3c, 8'h3c, 0}, '{10'h020, 8'h0e, 8'h0e, 0}, '{10'h021, 8'h77, 8'h00, 1},
      '{10'h013, 8'h11, 8'h00, 1}};
   // Rate code, accel level, gyro level, period multiple
   int rc [7][4] = '{'{0, 2, 1, 4}, '{1, 0, 3, 2}, '{3, 1, 0, 8}, '{0, 4, 4, 1},
      '{1, 4, 4, 2}, '{2, 4, 4, 4}, '{3, 4, 4, 8}};
   always #20 sys_clk = ~sys_clk;
   shs_slave_table #(.PERIOD_104(P), .PERIOD_52(2 * P), .PERIOD_26(4 * P),
      .PERIOD_12_5(8 * P)) u_shs_slave_table (.sys_clk(sys_clk), .rst_n(rst_n),
      .apbReq(apbReq), .apbRsp(apbRsp), .accelRateLevel(accelRateLevel),
      .gyroRateLevel(gyroRateLevel), .extWriteData(extWriteData), .txnValid(txnValid),
      .txn(txn), .txnDone(txnDone), .hubBusy(hubBusy), .pollTick(pollTick));
   shs_sensor_model u_shs_sensor_model (.sys_clk(sys_clk), .txnValid(txnValid),
      .slowMode(slowMode), .txnDone(txnDone));
   task automatic results();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic [9:0] i, input logic w, input logic [7:0] d);
      int k = 0;
      apbReq <= '{paddr: {i, 2'b00}, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: {24'h0, d}};
      @(posedge sys_clk);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         k++;
      end while (apbRsp.pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         fails++;
         results();
      end
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic waitTick(output int k);
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pollTick !== 1'b1 && k < 2000);
      if (k >= 2000) begin
         fails++;
         results();
      end
   endtask
   task automatic hubCycle(output int n);
      int k;
      n = 0;
      waitTick(k);
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
         if (txnValid === 1'b1 && txnDone === 1'b1 && n < 4) begin
            got[n] = txn;
            n++;
         end
      end while (hubBusy === 1'b1 && k < 400);
      if (hubBusy === 1'b1) begin
         fails++;
         results();
      end
   endtask
   function automatic logic [31:0] key(input shs_pkg::shs_txn_t t);
      return {10'h0, t.sensor, t.targetAddr, t.targetReg, t.write, t.readCount, t.queueEnable};
   endfunction
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      int n;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      foreach (rows[i]) begin
         apb(rows[i].idx, 1'b1, rows[i].wd);
         chk(err, rows[i].er);
         apb(rows[i].idx, 1'b0, 8'h00);
         chk(rd, {24'h0, rows[i].ex});
         chk(err, rows[i].er);
      end
      $display("register rows done");
      rst_n <= 1'b0;
      @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      for (int i = 'h14; i <= 'h20; i++) begin
         apb(10'(i), 1'b0, 8'h00);
         chk(rd, 32'h0);
      end
      $display("reset values done");
      apb(10'h015, 1'b1, 8'h55);
      apb(10'h016, 1'b1, 8'h5a);
      foreach (rc[i]) begin
         apb(10'h017, 1'b1, {2'(rc[i][0]), 6'h0b});
         accelRateLevel <= 3'(rc[i][1]);
         gyroRateLevel <= 3'(rc[i][2]);
         waitTick(n);
         waitTick(n);
         waitTick(n);
         chk(n, P * rc[i][3]);
      end
      $display("poll rate done");
      apb(10'h014, 1'b1, 8'h01);
      apb(10'h018, 1'b1, 8'h63);
      apb(10'h019, 1'b1, 8'hc4);
      apb(10'h01a, 1'b1, 8'h05);
      slowMode <= 1'b1;
      hubCycle(n);
      chk(n, 2);
      chk(key(got[0]), {10'h0, 2'h0, 7'h2a, 8'h5a, 5'h07});
      chk(key(got[1]), {10'h0, 2'h1, 7'h31, 8'hc4, 5'h0a});
      apb(10'h014, 1'b1, 8'h03);
      apb(10'h018, 1'b1, 8'h62);
      apb(10'h01b, 1'b1, 8'h0f);
      apb(10'h01c, 1'b1, 8'h33);
      apb(10'h01d, 1'b1, 8'h0a);
      apb(10'h01e, 1'b1, 8'h21);
      apb(10'h01f, 1'b1, 8'hee);
      apb(10'h020, 1'b1, 8'h01);
      slowMode <= 1'b0;
      hubCycle(n);
      chk(n, 3);
      chk(key(got[1]), {10'h0, 2'h2, 7'h07, 8'h33, 5'h05});
      chk(key(got[2]), {10'h0, 2'h3, 7'h10, 8'hee, 5'h02});
      apb(10'h014, 1'b1, 8'h00);
      apb(10'h015, 1'b1, 8'h54);
      extWriteData <= 8'ha7;
      hubCycle(n);
      chk(n, 1);
      chk(key(got[0]), {10'h0, 2'h0, 7'h2a, 8'h5a, 5'h10});
      chk(got[0].writeData, 8'ha7);
      $display("hub cycles done");
      results();
   end
endmodule
